// File: hdl/ilpc_pkg.sv
/*
  Constants for the interrupt priority controller: register offsets,
  field positions, reset values and source/vector counts.
  Assumes a 32-bit AXI4-Lite register bus with an 8-bit byte address.
*/
package ilpc_pkg;

  // Source and vector counts
  localparam int NUM_SRC   = 64;
  localparam int NUM_VEC   = 44;
  localparam int NUM_EXT   = 5;
  localparam int NUM_PWORD = 11;
  localparam int ADDR_W    = 8;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_STATUS  = 8'h04;
  localparam logic [7:0] OFF_VTBASE  = 8'h08;
  localparam logic [7:0] OFF_SPACING = 8'h0c;
  localparam logic [7:0] OFF_FLAG0   = 8'h10;
  localparam logic [7:0] OFF_FLAG1   = 8'h14;
  localparam logic [7:0] OFF_MASK0   = 8'h18;
  localparam logic [7:0] OFF_MASK1   = 8'h1c;
  localparam logic [7:0] OFF_SWSET0  = 8'h20;
  localparam logic [7:0] OFF_SWSET1  = 8'h24;
  localparam logic [7:0] OFF_PRIO    = 8'h40;

  // Control word fields
  localparam int CTRL_MVEC_BIT = 0;
  localparam int CTRL_POL_LSB  = 8;

  // Priority control word: slot k priority at 8k+4..8k+2, sub at 8k+1..8k
  localparam int PRIO_LSB   = 2;
  localparam int SLOT_PITCH = 8;

  // Reset values
  localparam logic [31:0] VTBASE_RST  = 32'h0000_0000;
  localparam logic [15:0] SPACING_RST = 16'h0000;
  localparam logic [2:0]  PRIO_RST    = 3'h0;
  localparam logic [1:0]  SUB_RST     = 2'h0;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: hdl/ilpc_axil.sv
/*
  AXI4-Lite slave front end. Turns bus traffic into one-cycle register
  write strobes and a combinational read lookup.
  Assumes the register file answers reads and hit flags combinationally.
*/
`timescale 1ns/1ps
module ilpc_axil (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             reg_we,
  output logic [7:0]       reg_waddr,
  output logic [31:0]      reg_wdata,
  output logic [3:0]       reg_wstrb,
  input  wire logic        reg_whit,
  output logic [7:0]       reg_raddr,
  input  wire logic [31:0] reg_rdata,
  input  wire logic        reg_rhit
);

  logic aw_full;
  logic w_full;

  // Address and data are held independently, so either may come first
  assign awready   = ~aw_full;
  assign wready    = ~w_full;
  assign reg_we    = aw_full & w_full & ~bvalid;
  assign arready   = ~rvalid;
  assign reg_raddr = araddr;

  ////////////////////////////////////////////////////////////////////////
  // Write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full   <= 1'b0;
      w_full    <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= ilpc_pkg::RESP_OKAY;
      reg_waddr <= 8'h00;
      reg_wdata <= 32'h0000_0000;
      reg_wstrb <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_full   <= 1'b1;
        reg_waddr <= awaddr;
      end
      if (wvalid && wready) begin
        w_full    <= 1'b1;
        reg_wdata <= wdata;
        reg_wstrb <= wstrb;
      end
      if (reg_we) begin
        aw_full <= 1'b0;
        w_full  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= reg_whit ? ilpc_pkg::RESP_OKAY : ilpc_pkg::RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read channel, data sampled at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= ilpc_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= reg_rdata;
      rresp  <= reg_rhit ? ilpc_pkg::RESP_OKAY : ilpc_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule

// File: hdl/ilpc_resolve.sv
/*
  Combinational ranking of pending vectors by priority, subpriority
  and vector number.
  Assumes pending bits already include enables and software triggers.
*/
`timescale 1ns/1ps
module ilpc_resolve (
  input  wire logic [43:0]  vec_pend,
  input  wire logic [131:0] vec_prio,
  input  wire logic [87:0]  vec_sub,
  output logic              found,
  output logic [5:0]        win_vec,
  output logic [2:0]        win_prio,
  output logic [1:0]        win_sub
);

  // Linear scan; strict compare keeps the lowest vector on a full tie
  always_comb begin
    found    = 1'b0;
    win_vec  = 6'h00;
    win_prio = 3'h0;
    win_sub  = 2'h0;
    for (int v = 0; v < ilpc_pkg::NUM_VEC; v++) begin
      if (vec_pend[v] && vec_prio[3*v +: 3] != 3'h0 &&
          {vec_prio[3*v +: 3], vec_sub[2*v +: 2]} >
          {win_prio, win_sub}) begin
        found    = 1'b1;
        win_vec  = 6'(v);
        win_prio = vec_prio[3*v +: 3];
        win_sub  = vec_sub[2*v +: 2];
      end
    end
  end

endmodule

// File: hdl/ilpc_top.sv
/*
  Interrupt priority controller top: event flags, enables, software
  triggers, external edge inputs, per-vector priority words, vector
  table addressing and the request presented to the core.
  Assumes peripheral events are pulses or levels on aclk; the external
  pins are asynchronous and are synchronised here.

  // Summary of operation
  // R1 - Collect peripheral events, rank them, then send one request to core
  // R2 - Sixty-four sources fold onto forty-four vectors
  // R3 - Single-vector mode shares one entry; multi-vector gives each its own
  // R4 - Five external inputs, each edge polarity selectable
  // R5 - Software write can set any source flag like hardware
  // R6 - Vector table base and entry spacing are software set
  // R7 - Seven priority levels, four subpriority levels per vector
  // R8 - Priority code zero disables the vector entirely
  // R9 - Priority codes one to seven are binary levels, seven highest
  // R10 - Subpriority code is binary, three highest, zero lowest
  // R11 - Fourth slot priority in bits 28-26, subpriority 25-24
  // R12 - Third slot priority in bits 20-18, subpriority 17-16
  // R13 - Second slot 12-10 and 9-8; first slot 4-2 and 1-0
  // R14 - Gap bits in priority words read zero, writes ignored
  // R15 - Highest priority wins, then subpriority, then lowest vector
  // R16 - All priority and subpriority fields reset to zero
*/
`timescale 1ns/1ps
module ilpc_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  input  wire logic [63:0] src_event,
  input  wire logic [4:0]  ext_int_pin,
  output logic             irq,
  output logic [5:0]       irq_vector,
  output logic [2:0]       irq_prio,
  output logic [1:0]       irq_subprio,
  output logic [31:0]      irq_vector_addr
);

  logic        reg_we;
  logic [7:0]  reg_waddr;
  logic [31:0] reg_wdata;
  logic [3:0]  reg_wstrb;
  logic        reg_whit;
  logic [7:0]  reg_raddr;
  logic [31:0] reg_rdata;
  logic        reg_rhit;

  logic        multi_vec;
  logic [4:0]  ext_rising;
  logic [31:0] vt_base;
  logic [15:0] vt_spacing;
  logic [63:0] flag;
  logic [63:0] enable;
  logic [63:0] flag_clr;
  logic [63:0] sw_set;
  logic [63:0] src_hit;
  logic [63:0] next_flag;
  logic [131:0] vec_prio;
  logic [87:0]  vec_sub;
  logic [43:0]  vec_pend;
  logic [4:0]  ext_sync1;
  logic [4:0]  ext_sync2;
  logic [4:0]  ext_prev;
  logic [4:0]  ext_edge;
  logic        found;
  logic [5:0]  win_vec;
  logic [2:0]  win_prio;
  logic [1:0]  win_sub;
  logic [5:0]  next_vector;
  logic [21:0] entry_offset;
  logic [31:0] next_addr;

  ////////////////////////////////////////////////////////////////////////
  // Bus front end
  ilpc_axil u_axil (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .awvalid   (s_axi_awvalid),
    .awready   (s_axi_awready),
    .awaddr    (s_axi_awaddr),
    .wvalid    (s_axi_wvalid),
    .wready    (s_axi_wready),
    .wdata     (s_axi_wdata),
    .wstrb     (s_axi_wstrb),
    .bvalid    (s_axi_bvalid),
    .bready    (s_axi_bready),
    .bresp     (s_axi_bresp),
    .arvalid   (s_axi_arvalid),
    .arready   (s_axi_arready),
    .araddr    (s_axi_araddr),
    .rvalid    (s_axi_rvalid),
    .rready    (s_axi_rready),
    .rdata     (s_axi_rdata),
    .rresp     (s_axi_rresp),
    .reg_we    (reg_we),
    .reg_waddr (reg_waddr),
    .reg_wdata (reg_wdata),
    .reg_wstrb (reg_wstrb),
    .reg_whit  (reg_whit),
    .reg_raddr (reg_raddr),
    .reg_rdata (reg_rdata),
    .reg_rhit  (reg_rhit)
  );

  ////////////////////////////////////////////////////////////////////////
  // Write decode
  wire [31:0] wmask = {{8{reg_wstrb[3]}}, {8{reg_wstrb[2]}},
                       {8{reg_wstrb[1]}}, {8{reg_wstrb[0]}}};
  wire [31:0] wbits = reg_wdata & wmask;
  wire we_ctrl  = reg_we && reg_waddr == ilpc_pkg::OFF_CTRL;
  wire we_base  = reg_we && reg_waddr == ilpc_pkg::OFF_VTBASE;
  wire we_space = reg_we && reg_waddr == ilpc_pkg::OFF_SPACING;
  wire we_flag0 = reg_we && reg_waddr == ilpc_pkg::OFF_FLAG0;
  wire we_flag1 = reg_we && reg_waddr == ilpc_pkg::OFF_FLAG1;
  wire we_mask0 = reg_we && reg_waddr == ilpc_pkg::OFF_MASK0;
  wire we_mask1 = reg_we && reg_waddr == ilpc_pkg::OFF_MASK1;
  wire we_sw0   = reg_we && reg_waddr == ilpc_pkg::OFF_SWSET0;
  wire we_sw1   = reg_we && reg_waddr == ilpc_pkg::OFF_SWSET1;
  wire w_prio   = reg_waddr >= ilpc_pkg::OFF_PRIO &&
                  reg_waddr < 8'(ilpc_pkg::OFF_PRIO + 4 * ilpc_pkg::NUM_PWORD);
  wire w_fixed  = reg_waddr <= ilpc_pkg::OFF_SWSET1 &&
                  reg_waddr[1:0] == 2'h0;
  // Status is read-only; a write there is accepted and has no effect
  assign reg_whit = w_prio || w_fixed;

  // Flag clear is write-one; software trigger is write-one-to-set
  assign flag_clr = {we_flag1 ? wbits : 32'h0, we_flag0 ? wbits : 32'h0};
  assign sw_set   = {we_sw1 ? wbits : 32'h0, we_sw0 ? wbits : 32'h0}; // R5

  ////////////////////////////////////////////////////////////////////////
  // Control, vector table and enable registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      multi_vec  <= 1'b0;
      ext_rising <= 5'h00;
      vt_base    <= ilpc_pkg::VTBASE_RST;
      vt_spacing <= ilpc_pkg::SPACING_RST;
      enable     <= 64'h0;
    end else begin
      if (we_ctrl && reg_wstrb[0])
        multi_vec <= reg_wdata[ilpc_pkg::CTRL_MVEC_BIT]; // R3
      if (we_ctrl && reg_wstrb[1])
        ext_rising <= reg_wdata[ilpc_pkg::CTRL_POL_LSB +: 5]; // R4
      if (we_base)
        vt_base <= (vt_base & ~wmask) | wbits; // R6
      if (we_space)
        vt_spacing <= (vt_spacing & ~wmask[15:0]) | wbits[15:0]; // R6
      if (we_mask0)
        enable[31:0] <= (enable[31:0] & ~wmask) | wbits;
      if (we_mask1)
        enable[63:32] <= (enable[63:32] & ~wmask) | wbits;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // External pins: two-stage synchroniser, then edge pick by polarity
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_sync1 <= 5'h00;
      ext_sync2 <= 5'h00;
      ext_prev  <= 5'h00;
    end else begin
      ext_sync1 <= ext_int_pin;
      ext_sync2 <= ext_sync1;
      ext_prev  <= ext_sync2;
    end
  end

  // Rising when the polarity bit is one, falling otherwise
  assign ext_edge = (ext_rising & ext_sync2 & ~ext_prev) |
                    (~ext_rising & ~ext_sync2 & ext_prev); // R4

  ////////////////////////////////////////////////////////////////////////
  // Source flags; a new event beats a same-cycle software clear
  assign src_hit   = src_event | sw_set |
                     {59'h0, ext_edge}; // R1 R5
  assign next_flag = (flag & ~flag_clr) | src_hit;

  always_ff @(posedge aclk) begin
    if (!aresetn)
      flag <= 64'h0;
    else
      flag <= next_flag;
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-vector priority fields and source folding
  // Source s lands on vector s mod 44, so vectors 0..19 carry two sources
  for (genvar v = 0; v < ilpc_pkg::NUM_VEC; v++) begin : g_vec
    localparam int SLOT = v % 4;
    localparam logic [7:0] WADDR = 8'(ilpc_pkg::OFF_PRIO + 4 * (v / 4));
    localparam int PLSB = SLOT * ilpc_pkg::SLOT_PITCH + ilpc_pkg::PRIO_LSB;
    localparam int SLSB = SLOT * ilpc_pkg::SLOT_PITCH;
    wire sel = reg_we && reg_waddr == WADDR && reg_wstrb[SLOT];

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        vec_prio[3*v +: 3] <= ilpc_pkg::PRIO_RST; // R16
        vec_sub[2*v +: 2]  <= ilpc_pkg::SUB_RST; // R16
      end else if (sel) begin
        vec_prio[3*v +: 3] <= reg_wdata[PLSB +: 3]; // R7 R11 R12 R13
        vec_sub[2*v +: 2]  <= reg_wdata[SLSB +: 2]; // R10 R11 R12 R13
      end
    end

    if (v + ilpc_pkg::NUM_VEC < ilpc_pkg::NUM_SRC) begin : g_two
      assign vec_pend[v] = (flag[v] & enable[v]) |
                           (flag[v + ilpc_pkg::NUM_VEC] &
                            enable[v + ilpc_pkg::NUM_VEC]); // R2
    end else begin : g_one
      assign vec_pend[v] = flag[v] & enable[v]; // R2
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Ranking
  ilpc_resolve u_resolve (
    .vec_pend (vec_pend),
    .vec_prio (vec_prio),
    .vec_sub  (vec_sub),
    .found    (found), // R8 R15
    .win_vec  (win_vec),
    .win_prio (win_prio), // R9
    .win_sub  (win_sub)
  );

  // Single-vector mode always points at the first table entry
  assign next_vector  = multi_vec ? win_vec : 6'h00; // R3
  assign entry_offset = 22'(next_vector * vt_spacing);
  assign next_addr    = vt_base + {10'h000, entry_offset}; // R6

  // Request registered so the core sees a clean, glitch-free level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq             <= 1'b0;
      irq_vector      <= 6'h00;
      irq_prio        <= 3'h0;
      irq_subprio     <= 2'h0;
      irq_vector_addr <= 32'h0000_0000;
    end else begin
      irq             <= found; // R1 R8
      irq_vector      <= next_vector;
      irq_prio        <= win_prio;
      irq_subprio     <= win_sub;
      irq_vector_addr <= next_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read decode; gap bits of priority words are rebuilt as zero
  wire [7:0]  pidx = reg_raddr - ilpc_pkg::OFF_PRIO;
  wire [3:0]  pw   = pidx[5:2];
  wire r_prio = reg_raddr >= ilpc_pkg::OFF_PRIO &&
                reg_raddr < 8'(ilpc_pkg::OFF_PRIO + 4 * ilpc_pkg::NUM_PWORD);
  wire r_fixed = reg_raddr <= ilpc_pkg::OFF_SWSET1 &&
                 reg_raddr[1:0] == 2'h0;
  logic [31:0] prio_word [ilpc_pkg::NUM_PWORD];

  for (genvar w = 0; w < ilpc_pkg::NUM_PWORD; w++) begin : g_word
    assign prio_word[w] = {
      3'h0, vec_prio[3*(4*w+3) +: 3], vec_sub[2*(4*w+3) +: 2], // R11
      3'h0, vec_prio[3*(4*w+2) +: 3], vec_sub[2*(4*w+2) +: 2], // R12
      3'h0, vec_prio[3*(4*w+1) +: 3], vec_sub[2*(4*w+1) +: 2], // R13
      3'h0, vec_prio[3*(4*w)   +: 3], vec_sub[2*(4*w)   +: 2]  // R14
    };
  end

  wire [31:0] ctrl_rd   = {19'h0, ext_rising, 7'h00, multi_vec};
  wire [31:0] status_rd = {20'h0, found, win_prio, win_sub, win_vec};
  assign reg_rhit  = r_prio || r_fixed;
  assign reg_rdata =
    r_prio                                   ? prio_word[pw]          :
    reg_raddr == ilpc_pkg::OFF_CTRL    ? ctrl_rd                :
    reg_raddr == ilpc_pkg::OFF_STATUS  ? status_rd              :
    reg_raddr == ilpc_pkg::OFF_VTBASE  ? vt_base                :
    reg_raddr == ilpc_pkg::OFF_SPACING ? {16'h0, vt_spacing}    :
    reg_raddr == ilpc_pkg::OFF_FLAG0   ? flag[31:0]             :
    reg_raddr == ilpc_pkg::OFF_FLAG1   ? flag[63:32]            :
    reg_raddr == ilpc_pkg::OFF_MASK0   ? enable[31:0]           :
    reg_raddr == ilpc_pkg::OFF_MASK1   ? enable[63:32]          :
                                         32'h0000_0000;

endmodule

// File: verif/ilpc_core_model.sv
/*
  Behavioural processor core: watches the ranked request and keeps the
  vector and entry address it would branch to.
  Assumes the request is a level on aclk; no acknowledge goes back.
*/
`timescale 1ns/1ps
module ilpc_core_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        irq,
  input  wire logic [5:0]  irq_vector,
  input  wire logic [31:0] irq_vector_addr,
  output logic             taken,
  output logic [5:0]       vec,
  output logic [31:0]      entry
);
  // Sample every edge; flags are cleared by software, not by us
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      taken <= 1'b0;
      vec   <= 6'h00;
      entry <= 32'h0000_0000;
    end else begin
      taken <= irq;
      vec   <= irq_vector;
      entry <= irq_vector_addr;
    end
  end
endmodule

// File: verif/ilpc_properties.sv
/*
  Port checker for the interrupt priority controller top.
  Assumes one clock, aclk, and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module ilpc_properties (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        irq,
  input wire logic [5:0]  irq_vector,
  input wire logic [2:0]  irq_prio,
  input wire logic [1:0]  irq_subprio
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////////////////////////////////
  // Request outputs
  live_prio_a: assert property (
    irq |-> irq_prio != 3'h0) else $error("irq with zero priority");
  idle_fields_a: assert property (
    !irq |-> irq_prio == 3'h0 && irq_subprio == 2'h0)
    else $error("fields set with irq low");
  vec_range_a: assert property (
    irq |-> irq_vector < 6'h2c) else $error("vector out of range");
  // Fields reset to zero, so nothing can request just after release
  reset_quiet_a: assert property (
    $rose(aresetn) |-> (!irq) [*3]) else $error("irq after reset");

  ////////////////////////////////////////////////////////////////////
  // Register bus answers stand until taken
  b_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  rd_lat_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  // A pending response holds the next write back, so only count from idle
  wr_lat_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
    !s_axi_bvalid |-> ##2 s_axi_bvalid) else $error("write answer late");
endmodule

bind ilpc_top ilpc_properties u_props (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .irq, .irq_vector, .irq_prio, .irq_subprio
);

// File: verif/ilpc_tb_top.sv
/*
  Bench for the interrupt priority controller: register rows, then
  ranking, external edges, masking, modes and a reset mid-run.
  Assumes the core model and the bound checker are compiled with it.
*/
`timescale 1ns/1ps
module ilpc_tb_top;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] w;
    logic [31:0] r;
    logic [1:0]  rs;
  } ilpc_row_t;
  localparam logic [1:0] OK = ilpc_pkg::RESP_OKAY;
  localparam logic [1:0] ER = ilpc_pkg::RESP_SLVERR;
  // Slot fields only; gap bits must drop, unmapped places refuse
  ilpc_row_t rows [8] = '{
    '{8'h40, 32'hffff_ffff, 32'h1f1f_1f1f, OK}, '{8'h44, 32'h1234_5678,
    32'h1214_1618, OK}, '{8'h68, 32'hffff_ffff, 32'h1f1f_1f1f, OK},
    '{8'h08, 32'h0000_1000, 32'h0000_1000, OK}, '{8'h0c, 32'habcd_0020,
    32'h0000_0020, OK}, '{8'h20, 32'h0000_0000, 32'h0000_0000, OK},
    '{8'h6c, 32'hffff_ffff, 32'h0, ER}, '{8'hf0, 32'h1, 32'h0, ER}};
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, irq_vector_addr, entry;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [63:0] src_event = 64'h0;
  logic [4:0]  ext_int_pin = 5'h1f;
  logic [1:0]  s_axi_bresp, s_axi_rresp, irq_subprio;
  logic [5:0]  irq_vector, vec;
  logic [2:0]  irq_prio;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq, taken;
  int   fails = 0, checks_done = 0;

  always #12.5 aclk = ~aclk;

  ilpc_top dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .src_event, .ext_int_pin,
    .irq, .irq_vector, .irq_prio, .irq_subprio, .irq_vector_addr);
  ilpc_core_model core (.aclk, .aresetn, .irq, .irq_vector,
    .irq_vector_addr, .taken, .vec, .entry);

  ////////////////////////////////////////////////////////////////////
  // Bus tasks; answers are held off a little to exercise stalls
  task automatic chk_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] e);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    repeat (2) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    checks_done++;
    if (s_axi_bresp !== e) begin
      fails++;
      $display("[ERR] %0t write %h resp %h", $time, a, s_axi_bresp);
    end
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] e);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    checks_done++;
    if (s_axi_rdata !== d || s_axi_rresp !== e) begin
      fails++;
      $display("[ERR] %0t read %h got %h", $time, a, s_axi_rdata);
    end
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    chk_wr(a, d, OK);
  endtask

  // Request as the core sees it; fields only matter while raised
  task automatic chk_irq(input logic e, input logic [5:0] v,
      input logic [2:0] p, input logic [1:0] s, input logic [31:0] ad);
    repeat (8) @(posedge aclk);
    checks_done++;
    if (taken !== e || (e && {vec, irq_prio, irq_subprio, entry} !==
        {v, p, s, ad})) begin
      fails++;
      $display("[ERR] %0t irq %b vec %h at %h", $time, taken, vec, entry);
    end
  endtask

  task automatic pulse(input int s);
    src_event[s] <= 1'b1;
    @(posedge aclk);
    src_event[s] <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic results;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < ilpc_pkg::NUM_PWORD; i++)
      chk_rd(8'h40 + 8'(4 * i), 32'h0, OK);
    foreach (rows[i]) begin
      chk_wr(rows[i].a, rows[i].w, rows[i].rs);
      chk_rd(rows[i].a, rows[i].r, rows[i].rs);
    end
    // Byte lane 1 alone touches only the second slot
    s_axi_wstrb <= 4'h2;
    wr(8'h44, 32'h0000_0000);
    s_axi_wstrb <= 4'hf;
    chk_rd(8'h44, 32'h1214_0018, OK);
    wr(8'h18, 32'hffff_ffff);
    wr(8'h1c, 32'hffff_ffff);
    wr(8'h00, 32'h1);
    wr(8'h40, 32'h0);
    wr(8'h20, 32'h2);
    chk_irq(1'b0, 6'h00, 3'h0, 2'h0, 32'h0);
    wr(8'h40, 32'h0000_0900);
    chk_irq(1'b1, 6'h01, 3'h2, 2'h1, 32'h1020);
    wr(8'h40, 32'h000b_0900);
    pulse(46);
    chk_irq(1'b1, 6'h02, 3'h2, 2'h3, 32'h1040);
    wr(8'h40, 32'h1c0b_0900);
    pulse(3);
    chk_irq(1'b1, 6'h03, 3'h7, 2'h0, 32'h1060);
    wr(8'h44, 32'h0000_001c);
    pulse(48);
    chk_irq(1'b1, 6'h03, 3'h7, 2'h0, 32'h1060);
    wr(8'h10, 32'h0000_0008);
    chk_irq(1'b1, 6'h04, 3'h7, 2'h0, 32'h1080);
    wr(8'h10, 32'hffff_ffff);
    wr(8'h14, 32'hffff_ffff);
    chk_irq(1'b0, 6'h00, 3'h0, 2'h0, 32'h0);
    // External inputs: pin 0 falling, pin 1 switched to rising
    wr(8'h40, 32'h1c0b_0904);
    ext_int_pin[0] <= 1'b0;
    chk_irq(1'b1, 6'h00, 3'h1, 2'h0, 32'h1000);
    wr(8'h00, 32'h0000_0201);
    ext_int_pin[1] <= 1'b0;
    chk_irq(1'b1, 6'h00, 3'h1, 2'h0, 32'h1000);
    ext_int_pin[1] <= 1'b1;
    chk_irq(1'b1, 6'h01, 3'h2, 2'h1, 32'h1020);
    wr(8'h18, 32'h0);
    chk_irq(1'b0, 6'h00, 3'h0, 2'h0, 32'h0);
    wr(8'h18, 32'hffff_ffff);
    wr(8'h00, 32'h0000_0200);
    chk_irq(1'b1, 6'h00, 3'h2, 2'h1, 32'h1000);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    chk_irq(1'b0, 6'h00, 3'h0, 2'h0, 32'h0);
    chk_rd(8'h40, 32'h0, OK);
    results();
  end

  // Watchdog; the sequence needs a few hundred cycles at most
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    results();
  end
endmodule
